// ---- src/tw_timer8.sv ----
// 8-bit timer/counter with two compare channels, APB slave
`timescale 1ns/1ps
`default_nettype none
module tw_timer8
   import tw_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Port logic: direction bits and ordinary port data
   input  wire logic        pin_dir_a,
   input  wire logic        pin_dir_b,
   input  wire logic        port_data_a,
   input  wire logic        port_data_b,
   // Pins
   output logic             wave_out_a,
   output logic             wave_oe_a,
   output logic             wave_out_b,
   output logic             wave_oe_b,
   input  wire logic        ext_count_pin,
   // Interrupt requests and vector acknowledges: ovf, match a, match b
   output logic      [2:0]  irq_req,
   input  wire logic [2:0]  irq_ack
);

   function automatic tw_kind_type mode_kind(input logic [2:0] wgm);
      unique case (wgm)
         3'd1, 3'd5: mode_kind = TW_PHASE;
         3'd3, 3'd7: mode_kind = TW_FAST;
         3'd2:       mode_kind = TW_CTC;
         default:    mode_kind = TW_NORMAL;
      endcase
   endfunction : mode_kind

   ////////////////////////////////////////////////////////////////////////
   tw_ctrl_a_type ctrl_a_reg, ctrl_a_next;
   tw_ctrl_b_type ctrl_b_reg, ctrl_b_next;
   logic [7:0]    cnt_reg, cnt_next;
   logic [7:0]    buf_reg [2], buf_next [2];
   logic [7:0]    ocr_reg [2], ocr_next [2];
   logic [3:0]    irq_en_reg, irq_en_next;
   logic [2:0]    flag_reg, flag_next;
   logic [1:0]    wave_reg, wave_next;
   logic          down_reg, down_next;
   logic          block_reg, block_next;
   logic [9:0]    psc_reg, psc_next;
   logic [2:0]    sync_reg;
   logic [31:0]   prdata_reg, prdata_next;

   tw_kind_type   kind;
   logic [2:0]    wgm;
   logic [7:0]    top;
   logic [1:0]    act [2];
   logic [1:0]    match;
   logic [1:0]    force_hit;
   logic          tick;
   logic          at_top;
   logic          bottom_evt;
   logic          top_evt;
   logic          nonpwm;
   logic          hit;
   logic          wr;
   logic          cnt_wr;
   logic [5:0]    idx;

   assign idx     = paddr[7:2];
   assign wgm     = {ctrl_b_reg.wgm2, ctrl_a_reg.wgm_lo};
   assign kind    = mode_kind(wgm);
   assign nonpwm  = (kind == TW_NORMAL) || (kind == TW_CTC);
   assign act[0]  = ctrl_a_reg.act_a;
   assign act[1]  = ctrl_a_reg.act_b;
   assign hit     = (paddr[1:0] == 2'b00) &&
                    (idx == TW_IDX_CTRL_A || idx == TW_IDX_CTRL_B ||
                     idx == TW_IDX_COUNT  || idx == TW_IDX_CMP_A  ||
                     idx == TW_IDX_CMP_B  || idx == TW_IDX_IRQ_EN ||
                     idx == TW_IDX_FLAGS);
   assign wr      = psel && penable && pwrite && hit;
   assign cnt_wr  = wr && (idx == TW_IDX_COUNT);
   // Zero wait states: read data is latched in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata  = prdata_reg;

   // Top is compare A in modes 2, 5 and 7, else MAX
   assign top        = (wgm == 3'd2 || wgm == 3'd5 || wgm == 3'd7) ?
                       ocr_reg[0] : TW_MAX;
   assign at_top     = (cnt_reg == top);
   assign bottom_evt = tick && at_top && (kind == TW_FAST);
   assign top_evt    = tick && at_top && !down_reg && (kind == TW_PHASE);

   ////////////////////////////////////////////////////////////////////////
   // Count clock select
   always_comb begin
      unique case (ctrl_b_reg.clk_sel)
         3'd0: tick = 1'b0;
         3'd1: tick = 1'b1;
         3'd2: tick = &psc_reg[TW_DIV8_BITS-1:0];
         3'd3: tick = &psc_reg[TW_DIV64_BITS-1:0];
         3'd4: tick = &psc_reg[TW_DIV256_BITS-1:0];
         3'd5: tick = &psc_reg[TW_DIV1024_BITS-1:0];
         // Pin is watched regardless of its direction
         3'd6: tick = sync_reg[2] && !sync_reg[1];
         3'd7: tick = sync_reg[1] && !sync_reg[2];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for counter, channels, flags and registers
   always_comb begin
      ctrl_a_next = ctrl_a_reg;
      ctrl_b_next = ctrl_b_reg;
      cnt_next    = cnt_reg;
      buf_next    = buf_reg;
      ocr_next    = ocr_reg;
      irq_en_next = irq_en_reg;
      flag_next   = flag_reg;
      wave_next   = wave_reg;
      down_next   = down_reg;
      block_next  = block_reg;
      psc_next    = psc_reg + 10'h001;
      prdata_next = prdata_reg;
      force_hit   = 2'b00;

      // Match is blocked on the first tick after a counter write
      for (int ch = 0; ch < 2; ch++) begin
         match[ch] = tick && !block_reg && (cnt_reg == ocr_reg[ch]);
      end

      // Counter sequence
      if (tick) begin
         block_next = 1'b0;
         unique case (kind)
            TW_NORMAL: cnt_next = cnt_reg + 8'h01;
            TW_CTC, TW_FAST:
               cnt_next = at_top ? TW_BOTTOM : cnt_reg + 8'h01;
            TW_PHASE: begin
               if (!down_reg) begin
                  if (at_top) begin
                     down_next = 1'b1;
                     cnt_next  = cnt_reg - 8'h01;
                  end else begin
                     cnt_next = cnt_reg + 8'h01;
                  end
               end else if (cnt_reg == TW_BOTTOM) begin
                  down_next = 1'b0;
                  cnt_next  = cnt_reg + 8'h01;
               end else begin
                  cnt_next = cnt_reg - 8'h01;
               end
            end
         endcase
      end

      // Register writes
      if (wr) begin
         unique case (idx)
            TW_IDX_CTRL_A: ctrl_a_next = tw_ctrl_a_type'(pwdata[7:0]);
            TW_IDX_CTRL_B: begin
               ctrl_b_next = tw_ctrl_b_type'(pwdata[3:0]);
               // Strobes only act in non-PWM modes, nothing is stored
               force_hit[0] = pwdata[TW_B_FORCE_A] && nonpwm;
               force_hit[1] = pwdata[TW_B_FORCE_B] && nonpwm;
            end
            TW_IDX_COUNT: begin
               cnt_next   = pwdata[7:0];
               block_next = 1'b1;
            end
            TW_IDX_CMP_A:  buf_next[0] = pwdata[7:0];
            TW_IDX_CMP_B:  buf_next[1] = pwdata[7:0];
            TW_IDX_IRQ_EN: irq_en_next = pwdata[3:0];
            TW_IDX_FLAGS:  flag_next   = flag_next & ~pwdata[2:0];
            default: ;
         endcase
      end
      flag_next = flag_next & ~irq_ack;

      // Overflow moment per mode; set after clears so the set wins
      if (tick && ((nonpwm && cnt_reg == TW_MAX) ||
                   (kind == TW_FAST && at_top) ||
                   (kind == TW_PHASE && down_reg &&
                    cnt_reg == TW_BOTTOM))) begin
         flag_next[TW_F_OVF] = 1'b1;
      end

      // Waveform per channel; software clear loses to a match
      for (int ch = 0; ch < 2; ch++) begin
         if (match[ch]) begin
            flag_next[TW_F_MA+ch] = 1'b1;
         end
         // Compare buffer update moment
         if (nonpwm || (kind == TW_FAST && bottom_evt) ||
             (kind == TW_PHASE && top_evt)) begin
            ocr_next[ch] = buf_next[ch];
         end
         unique case (kind)
            TW_NORMAL, TW_CTC: begin
               if (match[ch] || force_hit[ch]) begin
                  unique case (act[ch])
                     2'b01: wave_next[ch] = !wave_reg[ch];
                     2'b10: wave_next[ch] = 1'b0;
                     2'b11: wave_next[ch] = 1'b1;
                     default: ;
                  endcase
               end
            end
            TW_FAST: begin
               if (act[ch] == 2'b01 && ch == 0 && ctrl_b_reg.wgm2 &&
                   match[ch]) begin
                  wave_next[ch] = !wave_reg[ch];
               end else if (act[ch][1]) begin
                  if (bottom_evt) begin
                     wave_next[ch] = !act[ch][0];
                  end else if (match[ch] && ocr_reg[ch] != top) begin
                     wave_next[ch] = act[ch][0];
                  end
               end
            end
            TW_PHASE: begin
               if (act[ch] == 2'b01 && ch == 0 && ctrl_b_reg.wgm2 &&
                   match[ch]) begin
                  wave_next[ch] = !wave_reg[ch];
               end else if (act[ch][1]) begin
                  if (ocr_reg[ch] == top) begin
                     // Compare at top acts once at top, down-count sense
                     if (top_evt) begin
                        wave_next[ch] = !act[ch][0];
                     end
                  end else if (match[ch]) begin
                     wave_next[ch] = down_reg ? !act[ch][0] :
                                     act[ch][0];
                  end
               end
            end
         endcase
      end

      // Read data latched in setup cycle
      if (psel && !penable && !pwrite) begin
         prdata_next = 32'h0000_0000;
         unique case (idx)
            TW_IDX_CTRL_A:
               prdata_next[7:0] = {ctrl_a_reg.act_a, ctrl_a_reg.act_b,
                                   2'b00, ctrl_a_reg.wgm_lo};
            TW_IDX_CTRL_B:
               prdata_next[7:0] = {4'h0, ctrl_b_reg};
            TW_IDX_COUNT:  prdata_next[7:0] = cnt_reg;
            TW_IDX_CMP_A:  prdata_next[7:0] = buf_reg[0];
            TW_IDX_CMP_B:  prdata_next[7:0] = buf_reg[1];
            TW_IDX_IRQ_EN: prdata_next[3:0] = irq_en_reg;
            TW_IDX_FLAGS:  prdata_next[2:0] = flag_reg;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_a_reg <= tw_ctrl_a_type'(TW_RST_BYTE);
         ctrl_b_reg <= tw_ctrl_b_type'(TW_RST_BYTE[3:0]);
         cnt_reg    <= TW_RST_BYTE;
         buf_reg    <= '{TW_RST_BYTE, TW_RST_BYTE};
         ocr_reg    <= '{TW_RST_BYTE, TW_RST_BYTE};
         irq_en_reg <= TW_RST_BYTE[3:0];
         flag_reg   <= TW_RST_BYTE[2:0];
         wave_reg   <= 2'b00;
         down_reg   <= 1'b0;
         block_reg  <= 1'b0;
         psc_reg    <= 10'h000;
         sync_reg   <= 3'b000;
         prdata_reg <= 32'h0000_0000;
      end else begin
         ctrl_a_reg <= ctrl_a_next;
         ctrl_b_reg <= ctrl_b_next;
         cnt_reg    <= cnt_next;
         buf_reg    <= buf_next;
         ocr_reg    <= ocr_next;
         irq_en_reg <= irq_en_next;
         flag_reg   <= flag_next;
         wave_reg   <= wave_next;
         down_reg   <= down_next;
         block_reg  <= block_next;
         psc_reg    <= psc_next;
         // Stage 0 feeds only stage 1; edges use stages 1 and 2
         sync_reg   <= {sync_reg[1:0], ext_count_pin};
         prdata_reg <= prdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin muxing; PWM action 01 frees the pin unless A with mode bit 2
   assign wave_out_a = (act[0][1] || (act[0][0] && (nonpwm || wgm[2]))) ?
                       wave_reg[0] : port_data_a;
   assign wave_out_b = (act[1][1] || (act[1][0] && nonpwm)) ?
                       wave_reg[1] : port_data_b;
   assign wave_oe_a  = pin_dir_a;
   assign wave_oe_b  = pin_dir_b;
   assign irq_req    = flag_reg & irq_en_reg[2:0] &
                       {3{irq_en_reg[TW_B_GLOBAL]}};

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rsv_a;
      psel && !penable && !pwrite && idx == TW_IDX_CTRL_A
      |=> prdata[3:2] == 2'b00;
   endproperty
   a_rsv_a: assert property (p_rsv_a) else $error("ctrl a rsv");

   property p_rsv_b;
      psel && !penable && !pwrite && idx == TW_IDX_CTRL_B
      |=> prdata[7:4] == 4'h0;
   endproperty
   a_rsv_b: assert property (p_rsv_b) else $error("ctrl b hi");

   property p_stop;
      ctrl_b_reg.clk_sel == 3'd0 && !cnt_wr |=> $stable(cnt_reg);
   endproperty
   a_stop: assert property (p_stop) else $error("count moved");
   property p_wrap;
      kind == TW_NORMAL && tick && cnt_reg == TW_MAX && !cnt_wr
      |=> cnt_reg == TW_BOTTOM && flag_reg[TW_F_OVF];
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap");

   property p_ctc;
      (kind == TW_CTC || kind == TW_FAST) && tick && at_top && !cnt_wr
      |=> cnt_reg == TW_BOTTOM;
   endproperty
   a_ctc: assert property (p_ctc) else $error("no clear at top");

   property p_turn;
      kind == TW_PHASE && tick && !down_reg && at_top && !cnt_wr
      |=> down_reg && cnt_reg == $past(cnt_reg) - 8'h01;
   endproperty
   a_turn: assert property (p_turn) else $error("no reversal");

   property p_block;
      cnt_wr |=> !match[0] && !match[1];
   endproperty
   a_block: assert property (p_block) else $error("match kept");
   property p_flag_set;
      match[0] |=> flag_reg[TW_F_MA];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag lost");
   property p_force;
      force_hit[0] && act[0] == 2'b11 && !tick && irq_ack == 3'b000
      |=> wave_reg[0] && $stable(flag_reg) && $stable(cnt_reg);
   endproperty
   a_force: assert property (p_force) else $error("force failed");
   property p_irq;
      irq_req[TW_F_OVF] |-> irq_en_reg[TW_B_GLOBAL] && flag_reg[TW_F_OVF];
   endproperty
   a_irq: assert property (p_irq) else $error("bad request");
   c_wrap:  cover property (kind == TW_NORMAL && tick && cnt_reg == TW_MAX);
   c_turn:  cover property (top_evt);
   c_force: cover property (force_hit[1]);
   c_ext:   cover property (tick && ctrl_b_reg.clk_sel == 3'd7);

endmodule : tw_timer8
`default_nettype wire

// ---- src/tw_pkg.sv ----
// Register map, field layouts and modes of the 8-bit two-channel timer
// What this block does
// - Nonzero action field routes waveform to pin, but PWM 01 only on A with mode bit 2
// - Non-PWM actions: off, toggle, clear, set
// - Fast PWM channel A action decode
// - Phase correct channel A action decode
// - Channel B 01 reserved, 10/11 like A
// - Fast PWM compare at top acts at bottom
// - Phase correct compare at top acts at top
// - Reserved control bits read as zero
// - Normal and clear-on-match top, update, overflow
// - Phase correct modes update top, flag bottom
// - Fast PWM modes top and bottom update
// - Force strobe applies action in non-PWM
// - Strobe sets no flag, never clears, reads zero
// - Clock select: stop or prescaled clock
// - Clock select 110/111 external edges
// - External pin counts even as output
// - Counter readable and writable
// - Counter write blocks next tick's match
// - Fast PWM counts to top then clears
// - Phase correct reverses at top and bottom, no hold
// - Match flag sets, cleared by ack or one
// - Interrupt needs enable, global bit, flag
package tw_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] TW_IDX_CTRL_A  = 6'h30;
   localparam logic [5:0] TW_IDX_CTRL_B  = 6'h33;
   localparam logic [5:0] TW_IDX_COUNT   = 6'h32;
   localparam logic [5:0] TW_IDX_CMP_A   = 6'h36;
   localparam logic [5:0] TW_IDX_CMP_B   = 6'h3C;
   localparam logic [5:0] TW_IDX_IRQ_EN  = 6'h39;
   localparam logic [5:0] TW_IDX_FLAGS   = 6'h38;
   localparam logic [7:0] TW_RST_BYTE    = 8'h00;
   localparam logic [7:0] TW_MAX         = 8'hFF;
   localparam logic [7:0] TW_BOTTOM      = 8'h00;
   // Field positions
   localparam int TW_B_FORCE_A  = 7;
   localparam int TW_B_FORCE_B  = 6;
   localparam int TW_B_GLOBAL   = 3;
   localparam int TW_F_OVF      = 0;
   localparam int TW_F_MA       = 1;
   localparam int TW_F_MB       = 2;
   // Prescaler tap widths for divide by 8, 64, 256, 1024
   localparam int TW_DIV8_BITS    = 3;
   localparam int TW_DIV64_BITS   = 6;
   localparam int TW_DIV256_BITS  = 8;
   localparam int TW_DIV1024_BITS = 10;
   typedef struct packed {
      logic [1:0] act_a;
      logic [1:0] act_b;
      logic [1:0] rsv;
      logic [1:0] wgm_lo;
   } tw_ctrl_a_type;
   typedef struct packed {
      logic       wgm2;
      logic [2:0] clk_sel;
   } tw_ctrl_b_type;
   typedef enum logic [1:0] {
      TW_NORMAL,
      TW_CTC,
      TW_FAST,
      TW_PHASE
   } tw_kind_type;
endpackage : tw_pkg

// ---- verification/tw_pins.sv ----
// Port pin model: direction bits, port data, pull-ups, count pin
`timescale 1ns/1ps
`default_nettype none
module tw_pins (
   // Clock
   input  wire logic pclk,
   // Block pins
   input  wire logic wave_out_a,
   input  wire logic wave_oe_a,
   input  wire logic wave_out_b,
   input  wire logic wave_oe_b,
   // Port logic
   output logic      pin_dir_a,
   output logic      pin_dir_b,
   output logic      port_data_a,
   output logic      port_data_b,
   output logic      ext_count_pin,
   // Resolved pin levels
   output logic      pin_a,
   output logic      pin_b
);
   initial begin
      pin_dir_a     = 1'b1;
      pin_dir_b     = 1'b1;
      port_data_a   = 1'b0;
      port_data_b   = 1'b0;
      ext_count_pin = 1'b0;
   end
   // Released pins float up to the pull-up, not the last value
   assign pin_a = wave_oe_a ? wave_out_a : 1'b1;
   assign pin_b = wave_oe_b ? wave_out_b : 1'b1;
   task automatic set_port(input logic da, pa, db, pb);
      @(posedge pclk);
      pin_dir_a   <= da;
      port_data_a <= pa;
      pin_dir_b   <= db;
      port_data_b <= pb;
   endtask : set_port
   // Slow edges so the synchroniser sees each one
   task automatic toggle(input int n);
      repeat (n) begin
         repeat (8) @(posedge pclk);
         ext_count_pin <= ~ext_count_pin;
      end
      repeat (8) @(posedge pclk);
   endtask : toggle
endmodule : tw_pins
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the 8-bit two-channel timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tw_pkg::*;
   localparam logic [7:0] A_CA = {TW_IDX_CTRL_A, 2'b00};
   localparam logic [7:0] A_CB = {TW_IDX_CTRL_B, 2'b00};
   localparam logic [7:0] A_CN = {TW_IDX_COUNT, 2'b00};
   localparam logic [7:0] A_MA = {TW_IDX_CMP_A, 2'b00};
   localparam logic [7:0] A_MB = {TW_IDX_CMP_B, 2'b00};
   localparam logic [7:0] A_IE = {TW_IDX_IRQ_EN, 2'b00};
   localparam logic [7:0] A_FL = {TW_IDX_FLAGS, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, c0, diff;
   logic [31:0] pwdata, prdata, rd;
   logic        err, pin_a, pin_b, ext_count_pin;
   logic        pin_dir_a, pin_dir_b, port_data_a, port_data_b;
   logic        wave_out_a, wave_oe_a, wave_out_b, wave_oe_b;
   logic [2:0]  irq_req, irq_ack;
   logic [1:0]  act;
   int          errors, checks_done, cycles, ha, hb, dv;
   logic [7:0]  regs [7] = '{A_CA, A_CB, A_CN, A_MA, A_MB, A_IE, A_FL};
   int          divs [5] = '{1, 8, 64, 256, 1024};
   // ctrl_a, ctrl_b, cmp_a, cmp_b, period, highs a, highs b
   int          t [8][7] = '{
      '{'hB3, 1, 'h40, 'h40, 256, 65, 191},
      '{'hB3, 1, 'hFF, 'h40, 256, 256, 191},
      '{'hB1, 1, 'h40, 'h40, 510, 128, 382},
      '{'hB1, 1, 'hFF, 'h40, 510, 510, 382},
      '{'hB3, 9, 'h3F, 'h10, 64, 64, 47},
      '{'hB1, 9, 'h3F, 'h10, 126, 126, 94},
      '{'h73, 9, 'h3F, 'h10, 128, 64, 94},
      '{'h73, 1, 'h40, 'h40, 256, 256, 191}};
   tw_timer8 DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_dir_a(pin_dir_a), .pin_dir_b(pin_dir_b),
      .port_data_a(port_data_a), .port_data_b(port_data_b),
      .wave_out_a(wave_out_a), .wave_oe_a(wave_oe_a),
      .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b),
      .ext_count_pin(ext_count_pin), .irq_req(irq_req),
      .irq_ack(irq_ack));
   tw_pins PINS (.pclk(pclk), .wave_out_a(wave_out_a),
      .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b),
      .wave_oe_b(wave_oe_b), .pin_dir_a(pin_dir_a),
      .pin_dir_b(pin_dir_b), .port_data_a(port_data_a),
      .port_data_b(port_data_b), .ext_count_pin(ext_count_pin),
      .pin_a(pin_a), .pin_b(pin_b));
   ////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         conclude();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, e);
   endtask : rchk
   task automatic measure(input int p);
      ha = 0;
      hb = 0;
      repeat (p) begin
         @(negedge pclk);
         if (pin_a === 1'b1) ha++;
         if (pin_b === 1'b1) hb++;
      end
   endtask : measure
   ////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      irq_ack = 3'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      foreach (regs[i]) rchk(regs[i], 32'h0000_0000);
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
      wr(A_CA, 32'h0000_000C);
      rchk(A_CA, 32'h0000_0000);
      wr(A_CB, 32'h0000_00F0);
      rchk(A_CB, 32'h0000_0000);
      wr(A_CN, 32'h0000_005A);
      rchk(A_CN, 32'h0000_005A);
      $display("Test registers done");
      PINS.set_port(1'b1, 1'b1, 1'b1, 1'b0);
      @(negedge pclk);
      check({wave_oe_a, wave_oe_b, pin_a, pin_b}, 4'hE);
      PINS.set_port(1'b0, 1'b0, 1'b1, 1'b1);
      @(negedge pclk);
      check({wave_oe_a, wave_oe_b, pin_a, pin_b}, 4'h7);
      PINS.set_port(1'b1, 1'b0, 1'b1, 1'b0);
      for (int i = 0; i < 4; i++) begin
         act = (i == 0) ? 2'h3 : (i == 1) ? 2'h2 : 2'h1;
         wr(A_CA, {24'h0, act, act, 4'h0});
         wr(A_CB, 32'h0000_00C0);
         repeat (2) @(negedge pclk);
         check({pin_a, pin_b}, (i % 2) ? 2'h0 : 2'h3);
      end
      rchk(A_FL, 32'h0000_0000);
      $display("Test force done");
      wr(A_CA, 32'h0000_0000);
      wr(A_CN, 32'h0000_00F0);
      wr(A_CB, 32'h0000_0001);
      repeat (20) @(posedge pclk);
      wr(A_CB, 32'h0000_0000);
      rchk(A_FL, 32'h0000_0007);
      wr(A_IE, 32'h0000_0007);
      @(negedge pclk);
      check(irq_req, 3'h0);
      wr(A_IE, 32'h0000_000F);
      @(negedge pclk);
      check(irq_req, 3'h7);
      @(posedge pclk) irq_ack <= 3'h1;
      @(posedge pclk) irq_ack <= 3'h0;
      rchk(A_FL, 32'h0000_0006);
      wr(A_FL, 32'h0000_0006);
      rchk(A_FL, 32'h0000_0000);
      wr(A_IE, 32'h0000_0000);
      $display("Test flags done");
      wr(A_MB, 32'h0000_0020);
      for (int i = 0; i < 2; i++) begin
         wr(A_CN, i ? 32'h0000_001F : 32'h0000_0020);
         wr(A_CB, 32'h0000_0001);
         repeat (10) @(posedge pclk);
         wr(A_CB, 32'h0000_0000);
         rchk(A_FL, i ? 32'h0000_0004 : 32'h0000_0000);
         wr(A_FL, 32'h0000_0007);
      end
      for (int i = 0; i < 6; i++) begin
         dv = i ? divs[i-1] : 8;
         wr(A_CB, i);
         apb(1'b0, A_CN, 32'h0000_0000);
         c0 = rd[7:0];
         repeat (8 * dv - 3) @(posedge pclk);
         apb(1'b0, A_CN, 32'h0000_0000);
         diff = rd[7:0] - c0;
         check(diff, i ? 8'h08 : 8'h00);
      end
      wr(A_CB, 32'h0000_0000);
      wr(A_CN, 32'h0000_0000);
      wr(A_CB, 32'h0000_0007);
      PINS.toggle(3);
      rchk(A_CN, 32'h0000_0002);
      wr(A_CN, 32'h0000_0000);
      wr(A_CB, 32'h0000_0006);
      PINS.toggle(3);
      rchk(A_CN, 32'h0000_0002);
      $display("Test clock select done");
      wr(A_CB, 32'h0000_0000);
      wr(A_MA, 32'h0000_0010);
      wr(A_CN, 32'h0000_0000);
      wr(A_FL, 32'h0000_0007);
      wr(A_CA, 32'h0000_0042);
      wr(A_CB, 32'h0000_0001);
      measure(340);
      check(ha, 170);
      apb(1'b0, A_CN, 32'h0000_0000);
      check(rd <= 32'h0000_0010, 1'b1);
      rchk(A_FL, 32'h0000_0002);
      $display("Test clear on match done");
      PINS.set_port(1'b1, 1'b1, 1'b1, 1'b1);
      for (int r = 0; r < 8; r++) begin
         wr(A_CB, 32'h0000_0000);
         // Normal mode so both compare values load at once
         wr(A_CA, 32'h0000_0000);
         wr(A_MA, t[r][2]);
         wr(A_MB, t[r][3]);
         wr(A_CA, t[r][0]);
         wr(A_CN, 32'h0000_0000);
         wr(A_CB, t[r][1]);
         repeat (2 * t[r][4]) @(posedge pclk);
         measure(t[r][4]);
         check(ha, t[r][5]);
         check(hb, t[r][6]);
      end
      $display("Test pwm done");
      conclude();
   end
endmodule : tb_top
`default_nettype wire
